/* pkg/fws_regs.svh */
// Register map, field positions, reset values and timing counts of the
// flash write-status poller. Assumes a 10 MHz core clock and an APB master.
//
// Functional notes
// - Host reads status twice; unchanged toggle bit means done, next read is data.
// - Toggling with timeout error high: recheck; still toggling is failure, issue reset.
// - After leaving polling, host restarts with a fresh double read.
// - After timeout error host issues reset; device returns to read mode.
// - Host may skip erase timer checks if extra commands come within 50 us.
// - Host confirms acceptance, then reads erase timer bit around each sector command; the poller issues no sector commands and only reports DQ3 of its last read.
// - Status encodings per mode; host gives a valid address for polling reads.
`ifndef FWS_REGS_SVH
`define FWS_REGS_SVH

`define FWS_OFF_CTRL        12'h000
`define FWS_OFF_ADDR        12'h004
`define FWS_OFF_WDATA       12'h008
`define FWS_OFF_RDATA       12'h00C
`define FWS_OFF_STATUS      12'h010

`define FWS_OP_WRITE        3'h1
`define FWS_OP_READ         3'h2
`define FWS_OP_POLL         3'h3
`define FWS_OP_RESET        3'h4
`define FWS_OP_ABORT        3'h5

`define FWS_ST_BUSY         0
`define FWS_ST_DONE         1
`define FWS_ST_FAIL         2
`define FWS_ST_READY        3
`define FWS_ST_ERASE_TIMER  4
`define FWS_ST_TIMEOUT      5
`define FWS_ST_TOGGLE       6

`define FWS_DQ_POLL         7
`define FWS_DQ_TOGGLE1      6
`define FWS_DQ_TIMEOUT      5
`define FWS_DQ_ERASE_TIMER  3

`define FWS_RESET_CMD       16'h00F0
`define FWS_RST_ADDR        22'h000000
`define FWS_RST_DATA        16'h0000

`define FWS_CLK_NS          100
`define FWS_T_ACC_NS        90
`define FWS_T_WE_NS         100
`define FWS_T_RB_NS         200
`define FWS_SYNC_CYC        2
`define FWS_RD_CYC          (((`FWS_T_ACC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS) + `FWS_SYNC_CYC + 1)
`define FWS_WE_CYC          ((`FWS_T_WE_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_RB_CYC          (((`FWS_T_RB_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS) + `FWS_SYNC_CYC)

`endif

/* pkg/fws_pkg.sv */
// Types of the flash write-status poller: state encodings and state records.
// Assumes nothing from fws_regs.svh; the state encodings and field widths are written out here.
package fws_pkg;

  typedef enum logic [7:0] {
    FWS_IDLE = 8'h01,
    FWS_WR   = 8'h02,
    FWS_RD   = 8'h04,
    FWS_P1   = 8'h08,
    FWS_P2   = 8'h10,
    FWS_P3   = 8'h20,
    FWS_ARR  = 8'h40,
    FWS_RST  = 8'h80
  } fws_state_t;

  typedef enum logic [3:0] {
    FWS_C_IDLE   = 4'h1,
    FWS_C_SETUP  = 4'h2,
    FWS_C_STROBE = 4'h4,
    FWS_C_HOLD   = 4'h8
  } fws_cyc_state_t;

  typedef struct packed {
    fws_cyc_state_t st;
    logic [3:0]     cnt;
    logic           wr;
    logic [21:0]    addr;
    logic [15:0]    wdata;
    logic [15:0]    rdata;
    logic           ce_n;
    logic           oe_n;
    logic           we_n;
    logic           dq_oe;
    logic [15:0]    dq_s1;
    logic [15:0]    dq_s2;
  } fws_cyc_t;

  typedef struct packed {
    fws_state_t  st;
    logic        go;
    logic        go_wr;
    logic [21:0] go_addr;
    logic [15:0] go_data;
    logic [21:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        first;
    logic        done;
    logic        fail;
    logic        abort;
    logic        tmo_seen;
    logic        rb_s1;
    logic        rb_s2;
    logic [3:0]  settle;
    logic [31:0] prdata;
  } fws_main_t;

endpackage : fws_pkg

/* hw/fws_bus_cycle.sv */
// One asynchronous flash bus cycle, read or write, with fixed strobe timing.
// Assumes the flash data pins are resolved outside from flash_dq_oe.
`timescale 1ns/10ps
`include "fws_regs.svh"
module fws_bus_cycle (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  output logic [21:0]      flash_addr,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n
);

  fws_pkg::fws_cyc_t cur_ff;
  fws_pkg::fws_cyc_t nxt_cyc;

  always_comb begin
    nxt_cyc = cur_ff;
    nxt_cyc.dq_s1 = flash_dq_in;
    nxt_cyc.dq_s2 = cur_ff.dq_s1;
    case (cur_ff.st)
      fws_pkg::FWS_C_IDLE: begin
        if (start) begin
          nxt_cyc.wr    = is_write;
          nxt_cyc.addr  = addr;
          nxt_cyc.wdata = wdata;
          nxt_cyc.ce_n  = 1'b0;
          nxt_cyc.dq_oe = is_write;
          nxt_cyc.st    = fws_pkg::FWS_C_SETUP;
        end
      end
      fws_pkg::FWS_C_SETUP: begin
        if (cur_ff.wr) begin
          nxt_cyc.we_n = 1'b0;
          nxt_cyc.cnt  = 4'(`FWS_WE_CYC - 1);
        end else begin
          nxt_cyc.oe_n = 1'b0;
          nxt_cyc.cnt  = 4'(`FWS_RD_CYC - 1);
        end
        nxt_cyc.st = fws_pkg::FWS_C_STROBE;
      end
      fws_pkg::FWS_C_STROBE: begin
        if (cur_ff.cnt == 4'h0) begin
          // Rising strobe completes the cycle; each read is framed by its own strobes
          if (!cur_ff.wr) begin
            nxt_cyc.rdata = cur_ff.dq_s2;
          end
          nxt_cyc.we_n = 1'b1;
          nxt_cyc.oe_n = 1'b1;
          nxt_cyc.ce_n = 1'b1;
          nxt_cyc.st   = fws_pkg::FWS_C_HOLD;
        end else begin
          nxt_cyc.cnt = cur_ff.cnt - 4'h1;
        end
      end
      fws_pkg::FWS_C_HOLD: begin
        nxt_cyc.dq_oe = 1'b0;
        nxt_cyc.st    = fws_pkg::FWS_C_IDLE;
      end
      default: begin
        nxt_cyc.st = fws_pkg::FWS_C_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cur_ff <= '{st: fws_pkg::FWS_C_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      cur_ff <= nxt_cyc;
    end
  end

  assign done         = (cur_ff.st == fws_pkg::FWS_C_HOLD);
  assign rdata        = cur_ff.rdata;
  assign flash_addr   = cur_ff.addr;
  assign flash_dq_out = cur_ff.wdata;
  assign flash_dq_oe  = cur_ff.dq_oe;
  assign flash_ce_n   = cur_ff.ce_n;
  assign flash_oe_n   = cur_ff.oe_n;
  assign flash_we_n   = cur_ff.we_n;

endmodule : fws_bus_cycle

/* hw/fws_status_poller.sv */
// Host-side controller for a parallel NOR flash: single bus cycles on order,
// toggle-bit completion polling, timeout handling and ready/busy tracking.
// Assumes an APB master on the register side and a flash on the pin side.
`timescale 1ns/10ps
`include "fws_regs.svh"
module fws_status_poller (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [21:0]      flash_addr,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [15:0] flash_dq_in,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  input  wire logic        ready_busy_n
);

  fws_pkg::fws_main_t cur_ff;
  fws_pkg::fws_main_t nxt_main;

  logic        cyc_done;
  logic [15:0] cyc_rdata;
  logic        mapped;
  logic        wr_acc;
  logic        rd_setup;
  logic [2:0]  op;
  logic        busy;
  logic        rb_ready;
  logic [31:0] status_word;

  fws_bus_cycle fws_bus_cycle_inst (
    .core_clk     (core_clk),
    .srst         (srst),
    .start        (cur_ff.go),
    .is_write     (cur_ff.go_wr),
    .addr         (cur_ff.go_addr),
    .wdata        (cur_ff.go_data),
    .done         (cyc_done),
    .rdata        (cyc_rdata),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_dq_in  (flash_dq_in),
    .flash_ce_n   (flash_ce_n),
    .flash_oe_n   (flash_oe_n),
    .flash_we_n   (flash_we_n)
  );

  assign mapped   = (paddr == `FWS_OFF_CTRL) || (paddr == `FWS_OFF_ADDR) ||
                    (paddr == `FWS_OFF_WDATA) || (paddr == `FWS_OFF_RDATA) ||
                    (paddr == `FWS_OFF_STATUS);
  assign wr_acc   = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign op       = pwdata[2:0];
  assign busy     = (cur_ff.st != fws_pkg::FWS_IDLE);
  // Ready/busy is trusted only once the settle time after the last write strobe ran out
  assign rb_ready = cur_ff.rb_s2 && (cur_ff.settle == 4'h0);

  always_comb begin
    status_word = 32'h00000000;
    status_word[`FWS_ST_BUSY]        = busy;
    status_word[`FWS_ST_DONE]        = cur_ff.done;
    status_word[`FWS_ST_FAIL]        = cur_ff.fail;
    status_word[`FWS_ST_READY]       = rb_ready;
    // Timer bit always reported, so software may check it or skip it
    status_word[`FWS_ST_ERASE_TIMER] = cur_ff.rdata[`FWS_DQ_ERASE_TIMER];
    status_word[`FWS_ST_TIMEOUT]     = cur_ff.tmo_seen;
    status_word[`FWS_ST_TOGGLE]      = cur_ff.first;
  end

  always_comb begin
    nxt_main = cur_ff;
    nxt_main.go    = 1'b0;
    nxt_main.rb_s1 = ready_busy_n;
    nxt_main.rb_s2 = cur_ff.rb_s1;
    if (cur_ff.settle != 4'h0) begin
      nxt_main.settle = cur_ff.settle - 4'h1;
    end

    // Register reads are captured in the setup phase, answered in the access phase
    if (rd_setup) begin
      case (paddr)
        `FWS_OFF_ADDR:   nxt_main.prdata = {10'h000, cur_ff.addr};
        `FWS_OFF_WDATA:  nxt_main.prdata = {16'h0000, cur_ff.wdata};
        `FWS_OFF_RDATA:  nxt_main.prdata = {16'h0000, cur_ff.rdata};
        `FWS_OFF_STATUS: nxt_main.prdata = status_word;
        default:         nxt_main.prdata = 32'h00000000;
      endcase
    end

    if (wr_acc && (paddr == `FWS_OFF_ADDR) && !busy) begin
      nxt_main.addr = pwdata[21:0];
    end
    if (wr_acc && (paddr == `FWS_OFF_WDATA) && !busy) begin
      nxt_main.wdata = pwdata[15:0];
    end
    if (wr_acc && (paddr == `FWS_OFF_CTRL) && busy && (op == `FWS_OP_ABORT)) begin
      nxt_main.abort = 1'b1;
    end

    case (cur_ff.st)
      fws_pkg::FWS_IDLE: begin
        nxt_main.abort = 1'b0;
        if (wr_acc && (paddr == `FWS_OFF_CTRL)) begin
          nxt_main.go_addr = cur_ff.addr;
          nxt_main.go_data = cur_ff.wdata;
          nxt_main.go_wr   = 1'b0;
          case (op)
            `FWS_OP_WRITE: begin
              nxt_main.go    = 1'b1;
              nxt_main.go_wr = 1'b1;
              nxt_main.st    = fws_pkg::FWS_WR;
            end
            `FWS_OP_READ: begin
              nxt_main.go = 1'b1;
              nxt_main.st = fws_pkg::FWS_RD;
            end
            `FWS_OP_POLL: begin
              // Polling reads use the address held in the address register
              nxt_main.go       = 1'b1;
              nxt_main.tmo_seen = 1'b0;
              nxt_main.st       = fws_pkg::FWS_P1;
            end
            `FWS_OP_RESET: begin
              nxt_main.go      = 1'b1;
              nxt_main.go_wr   = 1'b1;
              nxt_main.go_addr = `FWS_RST_ADDR;
              nxt_main.go_data = `FWS_RESET_CMD;
              nxt_main.st      = fws_pkg::FWS_RST;
            end
            default: begin
              nxt_main.st = fws_pkg::FWS_IDLE;
            end
          endcase
          if (nxt_main.go) begin
            nxt_main.done = 1'b0;
            nxt_main.fail = 1'b0;
          end
        end
      end
      fws_pkg::FWS_WR, fws_pkg::FWS_RST: begin
        if (cyc_done) begin
          nxt_main.settle = 4'(`FWS_RB_CYC);
          nxt_main.done   = 1'b1;
          nxt_main.st     = fws_pkg::FWS_IDLE;
        end
      end
      fws_pkg::FWS_RD, fws_pkg::FWS_ARR: begin
        if (cyc_done) begin
          nxt_main.rdata = cyc_rdata;
          nxt_main.done  = 1'b1;
          nxt_main.st    = fws_pkg::FWS_IDLE;
        end
      end
      fws_pkg::FWS_P1: begin
        if (cyc_done) begin
          nxt_main.rdata = cyc_rdata;
          nxt_main.first = cyc_rdata[`FWS_DQ_TOGGLE1];
          nxt_main.go    = 1'b1;
          nxt_main.st    = fws_pkg::FWS_P2;
        end
      end
      fws_pkg::FWS_P2: begin
        if (cyc_done) begin
          nxt_main.rdata = cyc_rdata;
          nxt_main.first = cyc_rdata[`FWS_DQ_TOGGLE1];
          if (cyc_rdata[`FWS_DQ_TOGGLE1] == cur_ff.first) begin
            // Toggle stopped: the following read returns array data
            nxt_main.go = 1'b1;
            nxt_main.st = fws_pkg::FWS_ARR;
          end else if (cyc_rdata[`FWS_DQ_TIMEOUT]) begin
            nxt_main.tmo_seen = 1'b1;
            nxt_main.go       = 1'b1;
            nxt_main.st       = fws_pkg::FWS_P3;
          end else if (cur_ff.abort) begin
            // Leaving early; a later poll starts again from a double read
            nxt_main.st = fws_pkg::FWS_IDLE;
          end else begin
            nxt_main.go = 1'b1;
            nxt_main.st = fws_pkg::FWS_P2;
          end
        end
      end
      fws_pkg::FWS_P3: begin
        if (cyc_done) begin
          nxt_main.rdata = cyc_rdata;
          nxt_main.first = cyc_rdata[`FWS_DQ_TOGGLE1];
          nxt_main.go    = 1'b1;
          if (cyc_rdata[`FWS_DQ_TOGGLE1] == cur_ff.first) begin
            nxt_main.st = fws_pkg::FWS_ARR;
          end else begin
            // Still toggling with the timeout bit up: failed, return device to reading
            nxt_main.fail    = 1'b1;
            nxt_main.go_wr   = 1'b1;
            nxt_main.go_addr = `FWS_RST_ADDR;
            nxt_main.go_data = `FWS_RESET_CMD;
            nxt_main.st      = fws_pkg::FWS_RST;
          end
        end
      end
      default: begin
        nxt_main.st = fws_pkg::FWS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cur_ff <= '{st: fws_pkg::FWS_IDLE, rb_s1: 1'b1, rb_s2: 1'b1, default: '0};
    end else begin
      cur_ff <= nxt_main;
    end
  end

  assign prdata  = cur_ff.prdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

endmodule : fws_status_poller

/* sim/fws_status_poller_properties.sv */
// Checker of the poller's APB answers and flash strobe timing.
// Assumes it is bound to fws_status_poller and sees only its ports.
`timescale 1ns/10ps
module fws_status_poller_properties (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic        flash_dq_oe,
  input wire logic [15:0] flash_dq_in,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic        ready_busy_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_rd_low;
    (!flash_oe_n && !flash_ce_n) [*4];
  endsequence
  sequence s_rd_end;
    flash_oe_n && flash_ce_n;
  endsequence
  sequence s_wr_tail;
    (flash_we_n && flash_ce_n && flash_dq_oe) ##1 !flash_dq_oe;
  endsequence
  a_read_frame: assert property ($fell(flash_oe_n) |-> s_rd_low ##1 s_rd_end)
    else $error("read strobe length wrong");
  a_write_pulse: assert property ($fell(flash_we_n) |-> !flash_ce_n ##1 s_wr_tail)
    else $error("write strobe shape wrong");
  a_strobe_excl: assert property (!(!flash_oe_n && !flash_we_n))
    else $error("read and write strobes together");
  a_no_fight: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("data driven during read");
  a_ce_gap: assert property ($rose(flash_ce_n) |=> flash_ce_n)
    else $error("chip select gap missing");
  a_addr_hold: assert property (!flash_ce_n && !$fell(flash_ce_n) |-> $stable(flash_addr))
    else $error("address moved in cycle");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_slverr_map: assert property (psel && penable |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010}))
    else $error("pslverr does not match map");
  a_reset_idle: assert property (@(posedge core_clk) disable iff (1'h0)
    srst |=> flash_ce_n && flash_oe_n && flash_we_n && !flash_dq_oe)
    else $error("strobes active after reset");
endmodule : fws_status_poller_properties
bind fws_status_poller fws_status_poller_properties fws_status_poller_properties_inst (
  .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
  .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .ready_busy_n(ready_busy_n));

/* sim/fws_flash_model.sv */
// Behavioural flash: program runs for a set number of status reads.
// Assumes the bench resolves the data pins and pulls ready/busy up.
`timescale 1ns/10ps
module fws_flash_model (
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic [15:0] bus_in,
  input wire logic [7:0]  busy_reads,
  input wire logic        fail_mode,
  input wire logic        prot,
  output logic [15:0]     dq_drv,
  output logic            rb_low
);
  logic        busy, tmo, t1, in_rd, in_wr;
  logic [7:0]  left;
  logic [15:0] mem, pend, last;
  initial begin
    {busy, tmo, t1, in_rd, in_wr} = 5'h0;
    left = 8'h00;
    mem = 16'hA5C3;
    pend = 16'h0000;
    last = 16'h0000;
  end
  always @(negedge flash_we_n or negedge flash_oe_n or posedge flash_we_n or posedge flash_oe_n
           or posedge flash_ce_n) begin
    if (!flash_ce_n && !flash_we_n) in_wr = 1'h1;
    if (!flash_ce_n && !flash_oe_n) in_rd = 1'h1;
    if (in_wr && (flash_we_n || flash_ce_n)) begin
      in_wr = 1'h0;
      if (bus_in == 16'h00F0) begin
        busy = 1'h0;
        tmo = 1'h0;
      end else if (!busy) begin
        busy = fail_mode || busy_reads != 8'h00;
        tmo = fail_mode;
        left = busy_reads;
        pend = prot ? mem : bus_in;
        if (!busy) mem = pend;
      end
    end
    if (in_rd && (flash_oe_n || flash_ce_n)) begin
      in_rd = 1'h0;
      last = dq_drv;
      if (busy) begin
        t1 = ~t1;
        if (left != 8'h00) left = left - 8'h01;
        if (left == 8'h00 && !tmo) begin
          busy = 1'h0;
          mem = pend;
        end
      end
    end
  end
  // Status: poll bit inverted, second toggle and erase timer still
  always_comb begin
    if (flash_ce_n || flash_oe_n) dq_drv = ~last;
    else if (busy) dq_drv = {8'h00, ~pend[7], t1, tmo, 5'h00};
    else dq_drv = mem;
  end
  assign rb_low = busy;
endmodule : fws_flash_model

/* sim/fws_status_poller_tb.sv */
// Self-checking bench of the poller against the behavioural flash.
// Assumes fws_regs.svh offsets and status bit positions.
`timescale 1ns/10ps
`include "fws_regs.svh"
module fws_status_poller_tb;
  logic        core_clk, srst, psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st, rv;
  logic [21:0] flash_addr, wr_addr;
  logic [15:0] flash_dq_out, flash_dq_in, dq_drv, wr_data;
  logic        flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, rb_low, fail_mode, prot;
  wire         ready_busy_n;
  logic [7:0]  busy_reads;
  int          n_mismatch, cmp_count;
  always #50 core_clk = ~core_clk;
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : dq_drv;
  assign ready_busy_n = rb_low ? 1'h0 : 1'h1;
  always @(posedge flash_we_n) begin
    wr_data = flash_dq_out;
    wr_addr = flash_addr;
  end
  fws_status_poller fws_status_poller_inst (.core_clk(core_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .ready_busy_n(ready_busy_n));
  fws_flash_model fws_flash_model_inst (.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .bus_in(flash_dq_in), .busy_reads(busy_reads),
    .fail_mode(fail_mode), .prot(prot), .dq_drv(dq_drv), .rb_low(rb_low));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'h1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic op(input logic [2:0] c);
    int n;
    apb(1'h1, `FWS_OFF_CTRL, {29'h0, c}, rv);
    n = 0;
    st = 32'h0;
    while (st[`FWS_ST_DONE] !== 1'h1 && n < 300) begin
      apb(1'h0, `FWS_OFF_STATUS, 32'h0, st);
      n++;
    end
    chk("op_done", st[`FWS_ST_DONE], 1'h1);
  endtask : op
  task automatic prog_word(input logic [15:0] d);
    apb(1'h1, `FWS_OFF_ADDR, 32'h0000_0123, rv);
    apb(1'h1, `FWS_OFF_WDATA, {16'h0, d}, rv);
    op(`FWS_OP_WRITE);
  endtask : prog_word
  task automatic t_idle;
    apb(1'h0, 12'h014, 32'h0, rv);
    chk("unmapped_data", rv, 32'h0);
    chk("unmapped_err", last_err, 1'h1);
    op(`FWS_OP_POLL);
    chk("idle_fail", st[`FWS_ST_FAIL], 1'h0);
    chk("idle_toggle", st[`FWS_ST_TOGGLE], 1'h1);
    apb(1'h0, `FWS_OFF_RDATA, 32'h0, rv);
    chk("idle_rdata", rv, 32'h0000_A5C3);
  endtask : t_idle
  task automatic t_prog_ok;
    busy_reads = 8'h04;
    prog_word(16'h1214);
    apb(1'h0, `FWS_OFF_STATUS, 32'h0, st);
    chk("prog_ready", st[`FWS_ST_READY], 1'h0);
    op(`FWS_OP_READ);
    apb(1'h0, `FWS_OFF_RDATA, 32'h0, rv);
    chk("prog_status", rv[7:5], 3'h4);
    op(`FWS_OP_POLL);
    chk("prog_fail", st[`FWS_ST_FAIL], 1'h0);
    chk("prog_tmo", st[`FWS_ST_TIMEOUT], 1'h0);
    chk("prog_toggle", st[`FWS_ST_TOGGLE], 1'h0);
    apb(1'h0, `FWS_OFF_RDATA, 32'h0, rv);
    chk("prog_rdata", rv, 32'h0000_1214);
    apb(1'h0, `FWS_OFF_STATUS, 32'h0, st);
    chk("prog_ready_end", st[`FWS_ST_READY], 1'h1);
  endtask : t_prog_ok
  task automatic t_fail;
    fail_mode = 1'h1;
    busy_reads = 8'h02;
    prog_word(16'h00FF);
    op(`FWS_OP_POLL);
    fail_mode = 1'h0;
    chk("fail_flag", st[`FWS_ST_FAIL], 1'h1);
    chk("fail_tmo", st[`FWS_ST_TIMEOUT], 1'h1);
    chk("fail_cmd", wr_data, 16'h00F0);
    chk("fail_cmd_addr", wr_addr, 22'h000000);
    repeat (8) @(posedge core_clk);
    apb(1'h0, `FWS_OFF_STATUS, 32'h0, st);
    chk("fail_ready", st[`FWS_ST_READY], 1'h1);
  endtask : t_fail
  task automatic t_abort;
    int n;
    busy_reads = 8'h30;
    prog_word(16'h0F0F);
    apb(1'h1, `FWS_OFF_CTRL, {29'h0, `FWS_OP_POLL}, rv);
    repeat (30) @(posedge core_clk);
    apb(1'h1, `FWS_OFF_CTRL, {29'h0, `FWS_OP_ABORT}, rv);
    n = 0;
    st = 32'h1;
    while (st[`FWS_ST_BUSY] !== 1'h0 && n < 300) begin
      apb(1'h0, `FWS_OFF_STATUS, 32'h0, st);
      n++;
    end
    chk("abort_idle", st[`FWS_ST_BUSY], 1'h0);
    chk("abort_fail", st[`FWS_ST_FAIL], 1'h0);
    op(`FWS_OP_POLL);
    chk("resume_timer", st[`FWS_ST_ERASE_TIMER], 1'h1);
    apb(1'h0, `FWS_OFF_RDATA, 32'h0, rv);
    chk("resume_rdata", rv, 32'h0000_0F0F);
  endtask : t_abort
  task automatic t_prot;
    prot = 1'h1;
    busy_reads = 8'h02;
    prog_word(16'h5A5A);
    op(`FWS_OP_POLL);
    prot = 1'h0;
    chk("prot_fail", st[`FWS_ST_FAIL], 1'h0);
    apb(1'h0, `FWS_OFF_RDATA, 32'h0, rv);
    chk("prot_rdata", rv, 32'h0000_0F0F);
  endtask : t_prot
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    $display("BAD watchdog expected finish seen hang");
    wrap_up;
  end
  initial begin
    {core_clk, srst, psel, penable, pwrite, fail_mode, last_err} = 7'h20;
    paddr = 12'h000;
    pwdata = 32'h0;
    busy_reads = 8'h00;
    prot = 1'h0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (3) @(posedge core_clk);
    srst <= 1'h0;
    t_idle;
    t_prog_ok;
    t_fail;
    t_abort;
    t_prot;
    wrap_up;
  end
endmodule : fws_status_poller_tb
